/* File: include/pseq_pkg.sv */
// Shared constants and types for the program sequencer
package pseq_pkg;

  // Instruction word and address widths
  localparam int PC_W = 12;
  localparam int IW_W = 15;
  localparam int PM_DEPTH = 4096;

  // System clock periods per instruction cycle
  localparam int PHASES = 4;

  // Start-up wait in system clock periods, and the clock rate
  localparam int STARTUP_SYS_PERIODS = 1024;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_CYCLES = STARTUP_SYS_PERIODS;

  // Fixed program counter targets
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT_FIRST = 12'h004;
  localparam logic [11:0] VEC_EXT_SECOND = 12'h008;
  localparam logic [11:0] VEC_CMP = 12'h00c;
  localparam logic [11:0] VEC_TMR_FIRST = 12'h010;
  localparam logic [11:0] VEC_TMR_SECOND = 12'h014;
  localparam logic [11:0] VEC_ADC = 12'h018;

  // Interrupt source bit positions, highest priority first
  localparam int SRC_EXT_FIRST = 0;
  localparam int SRC_EXT_SECOND = 1;
  localparam int SRC_CMP = 2;
  localparam int SRC_TMR_FIRST = 3;
  localparam int SRC_TMR_SECOND = 4;
  localparam int SRC_ADC = 5;
  localparam int NSRC = 6;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PC_LOW_BYTE = 8'h06;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] IDX_IRQ_PENDING = 8'h21;
  localparam logic [7:0] IDX_SEQ_STATUS = 8'h22;

  // Register reset values
  localparam logic [5:0] IRQ_ENABLE_RST = 6'h00;
  localparam logic [11:0] PC_RST = VEC_RESET;

  // Run state of the sequencer
  typedef enum logic [2:0] {
    PSEQ_ST_START = 3'b001,
    PSEQ_ST_RUN = 3'b010,
    PSEQ_ST_HALT = 3'b100
  } pseq_state_t;

endpackage : pseq_pkg

/* File: hdl/pseq_timing.sv */
// Four-phase divider and start-up wait for the program sequencer
`timescale 1ns/100ps
`default_nettype none
module pseq_timing #(
  parameter int STARTUP = pseq_pkg::STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic halt_req,
  input wire logic wake_req,
  output logic [3:0] phase,
  output logic cyc_end,
  output logic running
);

  // Phase counter rests at zero outside the run state, so the first
  // instruction after a wake still gets all four phases
  logic [1:0] phase_ff;
  // Start-up wait counter
  logic [10:0] wait_ff;
  // Run state register
  pseq_pkg::pseq_state_t state_ff;
  pseq_pkg::pseq_state_t nxt_state;

  // One-hot phases; the last phase closes the instruction cycle
  assign phase = 4'h1 << phase_ff;
  assign cyc_end = (phase_ff == 2'(pseq_pkg::PHASES - 1)) && running;
  assign running = (state_ff == pseq_pkg::PSEQ_ST_RUN);

  // Next run state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      pseq_pkg::PSEQ_ST_START:
      begin
        // Fetching resumes only after the full wait
        if (wait_ff == 11'(STARTUP - 1))
          nxt_state = pseq_pkg::PSEQ_ST_RUN;
      end
      pseq_pkg::PSEQ_ST_RUN:
      begin
        // Halt takes effect at an instruction boundary only
        if (halt_req && cyc_end)
          nxt_state = pseq_pkg::PSEQ_ST_HALT;
      end
      pseq_pkg::PSEQ_ST_HALT:
      begin
        if (wake_req)
          nxt_state = pseq_pkg::PSEQ_ST_START;
      end
      default: nxt_state = pseq_pkg::PSEQ_ST_START;
    endcase
  end

  // Phase, wait counter and state registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_ff <= 2'h0;
      wait_ff <= 11'h000;
      state_ff <= pseq_pkg::PSEQ_ST_START;
    end
    else
    begin
      phase_ff <= running ? phase_ff + 2'h1 : 2'h0;
      wait_ff <= (state_ff == pseq_pkg::PSEQ_ST_START) ? wait_ff + 11'h001 : 11'h000;
      state_ff <= nxt_state;
    end
  end

endmodule : pseq_timing
`default_nettype wire

/* File: hdl/pseq_top.sv */
// Program sequencer: PC control, fetch pipeline, vectors and register slave
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Instruction cycle spans four system clocks.
// - Fetch next while executing previous instruction.
// - PC-changing instruction costs a dummy cycle.
// - PC advances by one after each fetch.
// - Reset clears PC to address zero.
// - First external interrupt vectors to 0x004.
// - Second external interrupt vectors to 0x008.
// - Comparator interrupt vectors to 0x00C.
// - Timer overflows vector to 0x010, 0x014.
// - Conversion-done interrupt vectors to 0x018.
// - Full stack: latch request, acknowledge after return.
// - Taken skip discards prefetch, PC plus two.
// - Low-byte write keeps upper bits, dummy cycle.
// - Jump and call load instruction address field.
// - Return reloads PC from stack top.
// - Program memory 4096 words of 15 bits.
// - Wait 1024 clocks after power-up or wake.
module pseq_top #(
  parameter int STARTUP = pseq_pkg::STARTUP_CYCLES,
  parameter int ADDR_W = 10
) (
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave, byte addressed
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Program memory fetch port
  output logic [11:0] pm_addr,
  input wire logic [14:0] pm_data,
  // Instruction handed to the execution unit
  output logic [14:0] instr,
  output logic instr_valid,
  output logic [11:0] instr_pc,
  output logic [3:0] phase,
  output logic cyc_end,
  // Outcome of the executing instruction, valid at cyc_end
  input wire logic exe_skip,
  input wire logic exe_jump,
  input wire logic exe_call,
  input wire logic exe_ret,
  input wire logic exe_halt,
  // Return stack
  input wire logic [11:0] stack_top,
  input wire logic stack_full,
  output logic stack_push,
  output logic stack_pop,
  output logic [11:0] stack_push_addr,
  // Interrupt sources and wake
  input wire logic ext_irq_first_n,
  input wire logic ext_irq_second_n,
  input wire logic cmp_irq,
  input wire logic tmr_first_irq,
  input wire logic tmr_second_irq,
  input wire logic adc_irq,
  input wire logic wake_req,
  output logic irq_ack,
  output logic [11:0] irq_vector,
  output logic running
);

  localparam int N = pseq_pkg::NSRC;

  // Program counter: address of the word being fetched
  logic [11:0] pc_ff;
  logic [11:0] nxt_pc;
  // Instruction register and its source address
  logic [14:0] ir_ff;
  logic [11:0] ir_pc_ff;
  // Low when the held word is a discarded prefetch
  logic ir_valid_ff;
  logic nxt_ir_valid;
  // Interrupt enable and pending flags
  logic [N-1:0] irq_en_ff;
  logic [N-1:0] irq_pend_ff;
  logic [N-1:0] nxt_irq_pend;
  // Pending low-byte write waiting for the cycle boundary
  logic lowbyte_wr_pend_ff;
  logic [7:0] lowbyte_data_ff;
  // Bus answer phase
  logic ack_ff;
  logic [31:0] rdata_ff;
  // Stack and interrupt pulses
  logic push_ff;
  logic pop_ff;
  logic [11:0] push_addr_ff;
  logic ack_irq_ff;
  logic [11:0] vec_ff;

  // Picks the highest priority pending source vector
  function automatic logic [11:0] pseq_vector(input logic [N-1:0] req);
    logic [11:0] v;
    v = pseq_pkg::VEC_RESET;
    if (req[pseq_pkg::SRC_ADC])
      v = pseq_pkg::VEC_ADC;
    if (req[pseq_pkg::SRC_TMR_SECOND])
      v = pseq_pkg::VEC_TMR_SECOND;
    if (req[pseq_pkg::SRC_TMR_FIRST])
      v = pseq_pkg::VEC_TMR_FIRST;
    if (req[pseq_pkg::SRC_CMP])
      v = pseq_pkg::VEC_CMP;
    if (req[pseq_pkg::SRC_EXT_SECOND])
      v = pseq_pkg::VEC_EXT_SECOND;
    if (req[pseq_pkg::SRC_EXT_FIRST])
      v = pseq_pkg::VEC_EXT_FIRST;
    return v;
  endfunction : pseq_vector

  // One-hot mask of the source that wins, used to clear it alone
  function automatic logic [N-1:0] pseq_winner(input logic [N-1:0] req);
    logic [N-1:0] w;
    w = '0;
    for (int i = N - 1; i >= 0; i--)
      if (req[i])
        w = N'(1) << i;
    return w;
  endfunction : pseq_winner

  // Timing: phases, cycle end and start-up wait
  pseq_timing #(
    .STARTUP(STARTUP)
  ) u_timing (
    .clk(clk),
    .srst(srst),
    .halt_req(exe_halt && ir_valid_ff),
    .wake_req(wake_req),
    .phase(phase),
    .cyc_end(cyc_end),
    .running(running)
  );

  // Raw interrupt requests; the external pins are active low
  wire [N-1:0] irq_raw = {adc_irq, tmr_second_irq, tmr_first_irq, cmp_irq,
                          ~ext_irq_second_n, ~ext_irq_first_n};
  wire [N-1:0] irq_ready = irq_pend_ff & irq_en_ff;

  // Outcome decode of the instruction in execute
  wire do_ret = ir_valid_ff && exe_ret;
  wire do_jump = ir_valid_ff && (exe_jump || exe_call);
  wire do_skip = ir_valid_ff && exe_skip;
  wire do_lowbyte = lowbyte_wr_pend_ff;
  wire transfer = do_ret || do_jump || do_skip || do_lowbyte;

  // An interrupt is only acknowledged with room on the stack; while
  // the stack is full the flag stays set and waits for a return
  wire take_irq = cyc_end && !transfer && (|irq_ready) && !stack_full;
  wire [N-1:0] irq_win = pseq_winner(irq_ready);

  // Bus decode on word index
  wire bus_req = avs_read || avs_write;
  wire [ADDR_W-3:0] word_idx = avs_address[ADDR_W-1:2];
  wire hit_lowbyte = (word_idx == (ADDR_W-2)'(pseq_pkg::IDX_PC_LOW_BYTE));
  wire hit_en = (word_idx == (ADDR_W-2)'(pseq_pkg::IDX_IRQ_ENABLE));
  wire hit_pend = (word_idx == (ADDR_W-2)'(pseq_pkg::IDX_IRQ_PENDING));
  wire hit_stat = (word_idx == (ADDR_W-2)'(pseq_pkg::IDX_SEQ_STATUS));
  // A write lands in the second cycle, when waitrequest is low
  wire wr_take = avs_write && ack_ff && avs_byteenable[0];
  wire rd_take = avs_read && !ack_ff;

  // One wait state on every access, mapped or not
  assign avs_waitrequest = bus_req && !ack_ff;
  assign avs_readdata = rdata_ff;

  // Next PC selection at the instruction boundary
  always_comb
  begin
    nxt_pc = pc_ff;
    nxt_ir_valid = ir_valid_ff;
    if (cyc_end)
    begin
      // Normal flow: fetched word goes to execute, PC steps on
      nxt_pc = pc_ff + 12'h001;
      nxt_ir_valid = 1'b1;
      if (do_lowbyte)
      begin
        // Upper four bits kept, short jump within 256 words
        nxt_pc = {pc_ff[11:8], lowbyte_data_ff};
        nxt_ir_valid = 1'b0;
      end
      else if (do_ret)
      begin
        nxt_pc = stack_top;
        nxt_ir_valid = 1'b0;
      end
      else if (do_jump)
      begin
        nxt_pc = ir_ff[11:0];
        nxt_ir_valid = 1'b0;
      end
      else if (do_skip)
      begin
        // Prefetched word dropped; it sat at instruction address + 1
        nxt_pc = pc_ff + 12'h001;
        nxt_ir_valid = 1'b0;
      end
      else if (take_irq)
      begin
        nxt_pc = pseq_vector(irq_ready);
        nxt_ir_valid = 1'b0;
      end
    end
  end

  // Pending flags: a new request beats the acknowledge clear
  always_comb
  begin
    nxt_irq_pend = irq_pend_ff;
    if (take_irq)
      nxt_irq_pend = nxt_irq_pend & ~irq_win;
    nxt_irq_pend = nxt_irq_pend | irq_raw;
  end

  // Program counter and fetch pipeline
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pc_ff <= pseq_pkg::PC_RST;
      ir_ff <= 15'h0000;
      ir_pc_ff <= 12'h000;
      ir_valid_ff <= 1'b0;
    end
    else
    begin
      pc_ff <= nxt_pc;
      ir_valid_ff <= nxt_ir_valid;
      if (cyc_end)
      begin
        // Word fetched this cycle executes in the next one
        ir_ff <= pm_data;
        ir_pc_ff <= pc_ff;
      end
    end
  end

  // Stack pushes for calls and acknowledged interrupts, pops for returns
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      push_ff <= 1'b0;
      pop_ff <= 1'b0;
      push_addr_ff <= 12'h000;
      ack_irq_ff <= 1'b0;
      vec_ff <= 12'h000;
    end
    else
    begin
      // The discarded prefetch address is where execution resumes
      push_ff <= cyc_end && !do_lowbyte && ((ir_valid_ff && exe_call && !do_ret) || take_irq);
      pop_ff <= cyc_end && !do_lowbyte && do_ret;
      push_addr_ff <= pc_ff;
      ack_irq_ff <= take_irq;
      vec_ff <= pseq_vector(irq_ready);
    end
  end

  // Interrupt flags
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_pend_ff <= '0;
    else
      irq_pend_ff <= nxt_irq_pend;
  end

  // Enable register write
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_en_ff <= pseq_pkg::IRQ_ENABLE_RST;
    else if (wr_take && hit_en)
      irq_en_ff <= avs_writedata[N-1:0];
  end

  // Low-byte write is held until the next instruction boundary, where it
  // replaces any jump, call, return or skip of the executing instruction
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lowbyte_wr_pend_ff <= 1'b0;
      lowbyte_data_ff <= 8'h00;
    end
    else if (wr_take && hit_lowbyte)
    begin
      lowbyte_wr_pend_ff <= 1'b1;
      lowbyte_data_ff <= avs_writedata[7:0];
    end
    else if (cyc_end)
      lowbyte_wr_pend_ff <= 1'b0;
  end

  // Bus answer: first cycle waits, read data captured for the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= bus_req && !ack_ff;
      if (rd_take)
      begin
        // Unmapped indices read as zero
        rdata_ff <= 32'h00000000;
        if (hit_lowbyte)
          rdata_ff <= {24'h000000, pc_ff[7:0]};
        if (hit_en)
          rdata_ff <= {26'h0000000, irq_en_ff};
        if (hit_pend)
          rdata_ff <= {26'h0000000, irq_pend_ff};
        if (hit_stat)
          rdata_ff <= {18'h00000, lowbyte_wr_pend_ff, running, pc_ff};
      end
    end
  end

  // Fetch address drives the 4096 x 15 program memory
  assign pm_addr = pc_ff;
  assign instr = ir_ff;
  assign instr_valid = ir_valid_ff && running;
  assign instr_pc = ir_pc_ff;
  assign stack_push = push_ff;
  assign stack_pop = pop_ff;
  assign stack_push_addr = push_addr_ff;
  assign irq_ack = ack_irq_ff;
  assign irq_vector = vec_ff;

endmodule : pseq_top
`default_nettype wire

/* File: tb/pseq_pmem.sv */
// Program memory model for the sequencer fetch port
`timescale 1ns/100ps
`default_nettype none
module pseq_pmem (
  input wire logic [11:0] addr,
  output logic [14:0] data
);
  // Combinational word; low field differs from its own address so jumps move
  assign data = {3'h5, addr ^ 12'h0f0};
endmodule : pseq_pmem
`default_nettype wire

/* File: tb/pseq_asserts.sv */
// Port-level checks for the program sequencer
`timescale 1ns/100ps
`default_nettype none
module pseq_asserts #(
  parameter int STARTUP = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [11:0] pm_addr,
  input wire logic [14:0] pm_data,
  input wire logic [14:0] instr,
  input wire logic instr_valid,
  input wire logic [11:0] instr_pc,
  input wire logic [3:0] phase,
  input wire logic cyc_end,
  input wire logic exe_skip,
  input wire logic exe_jump,
  input wire logic exe_ret,
  input wire logic [11:0] stack_top,
  input wire logic stack_full,
  input wire logic stack_pop,
  input wire logic irq_ack,
  input wire logic [11:0] irq_vector,
  input wire logic running,
  input wire logic wake_req
);
  logic [15:0] wcnt_ff; // Idle cycles since reset or wake
  logic [15:0] nxt_wcnt;
  // Restart on wake or while running so only the wait itself is counted
  assign nxt_wcnt = (running || wake_req) ? 16'h0000 : wcnt_ff + 16'h0001;
  // Wait counter register
  always_ff @(posedge clk)
  begin
    if (srst)
      wcnt_ff <= 16'h0000;
    else
      wcnt_ff <= nxt_wcnt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Last phase ends each cycle, no other end in the next three clocks
  chk_end_phase: assert property (cyc_end |-> phase == 4'h8 ##1 !cyc_end [*3])
    else $error("cycle end spacing wrong");
  chk_fetch_take: assert property (cyc_end |=> instr_pc == $past(pm_addr) && instr == $past(pm_data))
    else $error("fetched word not handed on");
  // Reset must act even though the others are disabled by it
  chk_reset_clear: assert property (disable iff (1'b0) srst |=> pm_addr == 12'h000 && !instr_valid)
    else $error("reset did not clear pc");
  chk_jump_load: assert property (cyc_end && instr_valid && exe_jump && !exe_ret |=>
    pm_addr == $past(instr[11:0]) && !instr_valid) else $error("jump target wrong");
  chk_ret_load: assert property (cyc_end && instr_valid && exe_ret |=> pm_addr == $past(stack_top) && stack_pop)
    else $error("return target wrong");
  chk_skip_two: assert property (cyc_end && instr_valid && exe_skip && !exe_jump && !exe_ret |=>
    pm_addr == $past(instr_pc) + 12'h002 && !instr_valid) else $error("skip wrong");
  chk_vec_take: assert property (irq_ack |-> !instr_valid && pm_addr == irq_vector &&
    irq_vector inside {12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018}) else $error("bad vector");
  chk_full_hold: assert property (cyc_end && stack_full |=> !irq_ack)
    else $error("ack with full stack");
  chk_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait state wrong");
  chk_start_wait: assert property ($rose(running) |-> wcnt_ff >= STARTUP - 1 && wcnt_ff <= STARTUP + 4)
    else $error("start-up wait wrong");
  // A run, after power-up or wake, opens on the first phase
  chk_run_align: assert property ($rose(running) |-> phase == 4'h1)
    else $error("run starts mid cycle");
endmodule : pseq_asserts
bind pseq_top pseq_asserts #(.STARTUP(STARTUP)) u_chk (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the program sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int STARTUP = 8; // Short start-up wait keeps the run brief
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf; // Full words only
  logic [11:0] pm_addr, instr_pc, stack_push_addr, irq_vector, cur;
  logic [11:0] stack_top = 12'h123; // Fixed return address
  logic [14:0] pm_data, instr;
  logic instr_valid, cyc_end, stack_push, stack_pop, irq_ack, running;
  logic [3:0] phase;
  logic exe_skip = 1'b0, exe_jump = 1'b0, exe_call = 1'b0, exe_ret = 1'b0, exe_halt = 1'b0;
  logic stack_full = 1'b0, wake_req = 1'b0;
  logic [5:0] src = 6'h00; // Raised sources, enable-register bit order
  logic [12:0] got_push; // Push strobe and address after a cycle end
  wire logic ext_irq_first_n = !src[0], ext_irq_second_n = !src[1], cmp_irq = src[2];
  wire logic tmr_first_irq = src[3], tmr_second_irq = src[4], adc_irq = src[5];
  int err_count = 0, n_checks = 0, i;
  always #5 clk = ~clk;
  pseq_top #(.STARTUP(STARTUP)) dut (.*);
  pseq_pmem u_pmem (.addr(pm_addr), .data(pm_data));
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // A wait that ran out counts as a mismatch
  task automatic tmo();
    err_count++;
    give_verdict();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 50)
      tmo();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    chk(v, exp);
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, idx, d, v);
  endtask : wr
  // Outcome f and sources s given to one instruction; next valid pc and dummy count checked
  task automatic step(input logic [4:0] f, input logic [5:0] s, input logic sf, input logic [11:0] exp,
                      input logic rel, input int dmy);
    int n;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      if (phase === 4'h2 && instr_valid === 1'b1)
        break;
    end
    if (n == 200)
      tmo();
    cur = instr_pc;
    @(posedge clk);
    src <= s;
    stack_full <= sf;
    @(posedge clk);
    src <= 6'h00;
    {exe_halt, exe_ret, exe_call, exe_jump, exe_skip} <= f;
    @(posedge clk);
    {exe_halt, exe_ret, exe_call, exe_jump, exe_skip} <= 5'h00;
    @(negedge clk);
    got_push = {stack_push, stack_push_addr};
    // Dummy slots last one instruction cycle each
    for (n = 0; n < 4 && instr_valid !== 1'b1; n++)
      repeat (4) @(negedge clk);
    chk(instr_pc, rel ? cur + exp : exp);
    chk(n, dmy);
  endtask : step
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(8'h22, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h41, 32'h0);
    for (i = 0; i < 300 && running !== 1'b1; i++)
      @(negedge clk);
    chk(running, 1'b1);
    step(5'h00, 6'h00, 1'b0, 12'h001, 1'b0, 0);
    step(5'h01, 6'h00, 1'b0, 12'h003, 1'b0, 1);
    step(5'h02, 6'h00, 1'b0, 12'h0f3, 1'b0, 1);
    step(5'h04, 6'h00, 1'b0, 12'h003, 1'b0, 1);
    chk(got_push, 13'h10f4);
    step(5'h08, 6'h00, 1'b0, 12'h123, 1'b0, 1);
    wr(8'h06, 32'h5a);
    for (i = 0; i < 40 && !(instr_valid === 1'b1 && instr_pc === 12'h15a); i++)
      @(negedge clk);
    chk(instr_pc, 12'h15a);
    // Masked source stays pending and untaken
    step(5'h00, 6'h01, 1'b0, 12'h001, 1'b1, 0);
    rd(8'h21, 32'h01);
    wr(8'h20, 32'h3e);
    for (i = 1; i < 6; i++)
    begin
      step(5'h00, 6'h01 << i, 1'b0, 12'(4 * (i + 1)), 1'b0, 1);
      chk(got_push, {1'b1, cur + 12'h001});
    end
    // Full stack holds off the waiting request until room appears
    step(5'h00, 6'h00, 1'b1, 12'h001, 1'b1, 0);
    wr(8'h20, 32'h3f);
    step(5'h00, 6'h00, 1'b1, 12'h001, 1'b1, 0);
    rd(8'h21, 32'h01);
    step(5'h00, 6'h00, 1'b0, 12'h004, 1'b0, 1);
    // Halt at the boundary: no valid word until a wake and the full wait
    step(5'h10, 6'h00, 1'b0, 12'h001, 1'b1, 4);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    for (i = 0; i < 300 && running !== 1'b1; i++)
      @(negedge clk);
    chk(i, STARTUP + 1);
    // Execution resumes with the word held over the halt
    step(5'h00, 6'h00, 1'b0, 12'h001, 1'b1, 0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
